// ==== common/ced_map.svh ====
/*
 Constants of the core external interrupt delivery block: widths, levels,
 reset values and pointer field positions.
 Assumes it is included by bare name ahead of the package declaration.
*/
`ifndef CED_MAP_SVH
`define CED_MAP_SVH

`define CED_NUM_SRC 255
`define CED_PRIO_W 4
`define CED_ID_W 8
`define CED_BASE_W 22
`define CED_PRIO_TOP 4'hF
`define CED_PRIO_NONE 4'h0
`define CED_ID_NONE 8'h00
`define CED_PTR_ID_LSB 2
`define CED_PTR_BASE_LSB 10
`define CED_PTR_RESET 32'h0000_0000
`define CED_SYNC_STAGES 2

`endif

// ==== common/ced_pkg.sv ====
/*
 Types shared by the core external interrupt delivery block.
 Assumes ced_map.svh is on the include path.
*/
`include "ced_map.svh"

package ced_pkg;
   typedef logic [`CED_PRIO_W-1:0] ced_prio_t;
   typedef logic [`CED_ID_W-1:0] ced_id_t;
   typedef logic [`CED_BASE_W-1:0] ced_base_t;

   // One node of the evaluation tree
   typedef struct packed {
      ced_prio_t prio;
      ced_id_t id;
   } ced_node_t;
endpackage

// ==== logic/ced_core.sv ====
/*
 Core-level interrupt controller: per-source gateways, comparator tree,
 threshold and wake compare, claim capture and hardware vector output.
 Assumes all inputs are synchronous to CLK except SRC_REQ, and that the
 hart's control register file drives the configuration ports directly.
*/
`include "ced_map.svh"

// Functional notes
// - Each source request passes a clock synchroniser before any priority evaluation.
// - Edge sources latch a pending flag on the active edge, shown as level.
// - Each source's pending state is readable in the consolidated pending bits.
// - Only pending and enabled sources feed their priority into the tree.
// - Each comparator forwards higher priority; on a tie the lower ID.
// - Tree output is maximum priority with lowest ID of all candidates.
// - Notify only while maximum priority exceeds both threshold and current level.
// - Notify state is mirrored as the hart's machine external pending bit.
// - Wake notice set when maximum priority is top level; drives hart wake.
// - Hart wakes only when global and external interrupt enables are both set.
// - Taking the interrupt clears global enable and jumps to the handler.
// - Capture write copies winner ID to pointer and priority to claim level.
// - Captured values ignore thresholds, current level and external enable.
// - Firmware clears an edge gateway via its clear write after servicing.
// - A cleared request drops out of evaluation immediately.
// - Evaluation runs continuously; notify follows any remaining qualifying source.
// - Claim contents change only on capture writes, each refreshing both.
// - Pointer word is 22-bit base, 8-bit winner ID and two zero bits.
// - Winner ID shifted left two bits forms a word offset into vector table.
// - Optional hardware vectoring presents the vector address selected by winner.
// - Reverse order inverts priority values at the ports; evaluation stays regular.
module ced_core
   import ced_pkg::*;
#(
   parameter int NUM_SRC = `CED_NUM_SRC
) (
   input wire logic CLK,
   input wire logic RESET,
   input wire logic [NUM_SRC-1:0] SRC_REQ,
   input wire logic [NUM_SRC-1:0] GW_EDGE_TYPE,
   input wire logic [NUM_SRC-1:0] GW_POLARITY_LOW,
   input wire logic [NUM_SRC-1:0] SRC_ENABLE,
   input wire logic [NUM_SRC*`CED_PRIO_W-1:0] SRC_PRIORITY,
   input wire logic [NUM_SRC-1:0] GW_CLEAR_WR,
   input wire logic PRIO_REVERSE,
   input wire logic [`CED_PRIO_W-1:0] PRIO_THRESH,
   input wire logic [`CED_PRIO_W-1:0] CUR_LEVEL,
   input wire logic [`CED_BASE_W-1:0] VEC_BASE,
   input wire logic CAPTURE_WR,
   input wire logic MSTATUS_MIE,
   input wire logic MIE_MEIE,
   input wire logic TAKE_EXT_IRQ,
   output logic [NUM_SRC:0] PENDING_BITS,
   output logic EXT_IRQ_NOTIFY,
   output logic MIP_MEIP,
   output logic WAKE_NOTICE,
   output logic WAKE_HART,
   output logic [31:0] HANDLER_POINTER,
   output logic [`CED_PRIO_W-1:0] CLAIM_LEVEL,
   output logic MIE_CLEAR,
   output logic JUMP_VALID,
   output logic [31:0] JUMP_ADDR
);

   localparam int TREE = 2 ** $clog2(NUM_SRC + 1);

   // Port priorities are inverted in reverse order; logic runs in regular order
   function automatic ced_prio_t to_regular(input ced_prio_t p, input logic rev);
      return rev ? ~p : p;
   endfunction

   // One comparator: higher priority wins, lower ID wins a tie
   function automatic ced_node_t cmp2(input ced_node_t a, input ced_node_t b);
      if (b.prio > a.prio) begin
         return b;
      end
      return a;
   endfunction

   // Pointer word: base, claim ID as word offset, two zero bits
   function automatic logic [31:0] make_ptr(input ced_base_t base, input ced_id_t id);
      return {base, id, 2'b00};
   endfunction

   logic [NUM_SRC-1:0] sync1_r;
   logic [NUM_SRC-1:0] sync2_r;
   logic [NUM_SRC-1:0] sync3_r;
   logic [NUM_SRC-1:0] pend_r;
   logic [NUM_SRC-1:0] active;
   logic [NUM_SRC-1:0] rise;
   ced_node_t node [1:2*TREE-1];
   ced_node_t winner;
   ced_prio_t thresh_int;
   ced_prio_t curlvl_int;
   logic notify_nxt;
   logic ext_irq_notify_r;
   logic mip_meip_r;
   logic wake_notice_r;
   logic wake_hart_r;
   logic [31:0] handler_pointer_r;
   ced_prio_t claim_level_r;
   logic mie_clear_r;
   logic jump_valid_r;
   logic [31:0] jump_addr_r;

   // Two-flop synchroniser plus one history flop for edge detection
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         sync1_r <= '0;
         sync2_r <= '0;
         sync3_r <= '0;
      end else begin
         sync1_r <= SRC_REQ;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   // Polarity applied after the synchroniser so stage one feeds only stage two
   assign active = sync2_r ^ GW_POLARITY_LOW;
   assign rise = active & ~(sync3_r ^ GW_POLARITY_LOW);

   // Gateway pending: level follows the source, edge latches; set beats clear
   // Giving the rise priority means a new edge arriving during the clear
   // write is never lost; firmware sees it pending again afterwards
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         pend_r <= '0;
      end else begin
         for (int s = 0; s < NUM_SRC; s++) begin
            if (!GW_EDGE_TYPE[s]) begin
               pend_r[s] <= active[s];
            end else if (rise[s]) begin
               pend_r[s] <= 1'b1;
            end else if (GW_CLEAR_WR[s]) begin
               pend_r[s] <= 1'b0;
            end
         end
      end
   end

   // ID 0 never pends, so its bit reads zero
   assign PENDING_BITS = {pend_r, 1'b0};

   // Evaluation tree, unstaged; leaf 0 and unused leaves carry priority zero
   // Left children always hold lower IDs, so keeping the left input on a tie
   // gives the lower ID without any ID compare; depth grows with log2 sources
   always_comb begin
      for (int i = 0; i < TREE; i++) begin
         node[TREE+i].id = ced_id_t'(i);
         node[TREE+i].prio = `CED_PRIO_NONE;
         if (i >= 1 && i <= NUM_SRC) begin
            if (pend_r[i-1] && SRC_ENABLE[i-1]) begin
               node[TREE+i].prio = to_regular(SRC_PRIORITY[(i-1)*`CED_PRIO_W +: `CED_PRIO_W],
                                              PRIO_REVERSE);
            end
         end
      end
      for (int n = TREE - 1; n >= 1; n--) begin
         node[n] = cmp2(node[2*n], node[2*n+1]);
      end
   end

   // A zero priority never wins a claim, so an empty tree yields ID 0
   assign winner = (node[1].prio == `CED_PRIO_NONE) ? '0 : node[1];

   assign thresh_int = to_regular(PRIO_THRESH, PRIO_REVERSE);
   assign curlvl_int = to_regular(CUR_LEVEL, PRIO_REVERSE);
   assign notify_nxt = (winner.prio > thresh_int) && (winner.prio > curlvl_int);

   // Notification, its mirror and wake; recomputed every cycle
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         ext_irq_notify_r <= 1'b0;
         mip_meip_r <= 1'b0;
         wake_notice_r <= 1'b0;
         wake_hart_r <= 1'b0;
      end else begin
         ext_irq_notify_r <= notify_nxt;
         mip_meip_r <= notify_nxt;
         wake_notice_r <= (winner.prio == `CED_PRIO_TOP);
         wake_hart_r <= (winner.prio == `CED_PRIO_TOP) && MSTATUS_MIE && MIE_MEIE;
      end
   end

   // Claim capture holds between writes; raw winner, no threshold gating
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         handler_pointer_r <= `CED_PTR_RESET;
         claim_level_r <= `CED_PRIO_NONE;
      end else if (CAPTURE_WR) begin
         handler_pointer_r <= make_ptr(VEC_BASE, winner.id);
         claim_level_r <= to_regular(winner.prio, PRIO_REVERSE);
      end
   end

   // Interrupt take: clear global enable and present the hardware vector
   // The address reloads on every take so it never shows a stale winner
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         mie_clear_r <= 1'b0;
         jump_valid_r <= 1'b0;
         jump_addr_r <= `CED_PTR_RESET;
      end else begin
         mie_clear_r <= TAKE_EXT_IRQ && ext_irq_notify_r && MSTATUS_MIE && MIE_MEIE;
         jump_valid_r <= TAKE_EXT_IRQ && ext_irq_notify_r && MSTATUS_MIE && MIE_MEIE;
         if (TAKE_EXT_IRQ) begin
            jump_addr_r <= make_ptr(VEC_BASE, winner.id);
         end
      end
   end

   assign EXT_IRQ_NOTIFY = ext_irq_notify_r;
   assign MIP_MEIP = mip_meip_r;
   assign WAKE_NOTICE = wake_notice_r;
   assign WAKE_HART = wake_hart_r;
   assign HANDLER_POINTER = handler_pointer_r;
   assign CLAIM_LEVEL = claim_level_r;
   assign MIE_CLEAR = mie_clear_r;
   assign JUMP_VALID = jump_valid_r;
   assign JUMP_ADDR = jump_addr_r;

   // Checks on the delivered behaviour
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RESET);

   chk_notify_thresh: assert property (
      EXT_IRQ_NOTIFY == ($past(winner.prio) > $past(thresh_int)
                         && $past(winner.prio) > $past(curlvl_int)))
      else $error("notify disagrees with threshold compare");

   chk_meip_mirror: assert property (
      MIP_MEIP == EXT_IRQ_NOTIFY)
      else $error("mip external bit differs from notify");

   chk_wake_top: assert property (
      WAKE_NOTICE == ($past(winner.prio) == `CED_PRIO_TOP))
      else $error("wake notice wrong for maximum priority");

   chk_wake_gate: assert property (
      WAKE_HART |-> WAKE_NOTICE && $past(MSTATUS_MIE) && $past(MIE_MEIE))
      else $error("hart woken without both enables");

   chk_claim_copy: assert property (
      CAPTURE_WR |=> HANDLER_POINTER[`CED_PTR_BASE_LSB-1:`CED_PTR_ID_LSB] == $past(winner.id)
                     && CLAIM_LEVEL == to_regular($past(winner.prio), $past(PRIO_REVERSE)))
      else $error("capture did not copy winner");

   chk_claim_hold: assert property (
      !CAPTURE_WR |=> $stable(HANDLER_POINTER) && $stable(CLAIM_LEVEL))
      else $error("claim changed without capture write");

   chk_ptr_zero: assert property (
      HANDLER_POINTER[1:0] == 2'b00 && JUMP_ADDR[1:0] == 2'b00)
      else $error("pointer low bits not zero");

   chk_take_clear: assert property (
      TAKE_EXT_IRQ && EXT_IRQ_NOTIFY && MSTATUS_MIE && MIE_MEIE |=> MIE_CLEAR && JUMP_VALID)
      else $error("take did not clear enable and jump");

   // Pulses must not appear without a take request
   chk_take_idle: assert property (
      !TAKE_EXT_IRQ |=> !MIE_CLEAR && !JUMP_VALID)
      else $error("take pulse without request");

   // Hardware vector follows the live winner at the take edge
   chk_jump_addr: assert property (
      TAKE_EXT_IRQ |=> JUMP_ADDR == make_ptr($past(VEC_BASE), $past(winner.id)))
      else $error("jump address not from winner");

   // Base field of the pointer is the table base at capture
   chk_ptr_base: assert property (
      CAPTURE_WR |=> HANDLER_POINTER[31:`CED_PTR_BASE_LSB] == $past(VEC_BASE))
      else $error("pointer base not captured");

   // Wake must reach the hart whenever both enables allow it
   chk_wake_on: assert property (
      WAKE_HART == ($past(winner.prio) == `CED_PRIO_TOP && $past(MSTATUS_MIE)
                    && $past(MIE_MEIE)))
      else $error("hart wake missing with both enables");

   // ID 0 is reserved for nothing pending and never reads as pending
   chk_pend_zero: assert property (
      PENDING_BITS[0] == 1'b0)
      else $error("pending bit zero set");

   // Per-source gateway and winner checks
   for (genvar g = 0; g < NUM_SRC; g++) begin : g_chk
      sequence seq_edge_in;
         GW_EDGE_TYPE[g] && (SRC_REQ[g] ^ GW_POLARITY_LOW[g]) == 1'b0
         ##1 GW_EDGE_TYPE[g] && (SRC_REQ[g] ^ GW_POLARITY_LOW[g]) == 1'b1;
      endsequence
      sequence seq_held;
         (GW_EDGE_TYPE[g] && $stable(GW_POLARITY_LOW[g])
          && (SRC_REQ[g] ^ GW_POLARITY_LOW[g]) == 1'b1) [*2];
      endsequence
      // Three edges from pin to flag: sync1, sync2, then the pending flop itself
      chk_edge_latch: assert property (
         seq_edge_in ##0 seq_held |=> ##1 pend_r[g])
         else $error("edge request not latched");
      chk_gw_clear: assert property (
         GW_EDGE_TYPE[g] && GW_CLEAR_WR[g] && !rise[g] |=> !pend_r[g])
         else $error("gateway clear ignored");

      // A rise must win over a clear in the same cycle
      chk_set_wins: assert property (
         GW_EDGE_TYPE[g] && rise[g] |=> pend_r[g])
         else $error("edge rise lost to clear");

      // Edge flag is sticky until firmware clears it
      chk_edge_keep: assert property (
         GW_EDGE_TYPE[g] && pend_r[g] && !GW_CLEAR_WR[g] |=> pend_r[g])
         else $error("edge pending dropped without clear");

      // Level gateways carry no state: the flag is the synchronised pin
      chk_level_follow: assert property (
         !GW_EDGE_TYPE[g] |=> pend_r[g] == $past(sync2_r[g] ^ GW_POLARITY_LOW[g]))
         else $error("level pending does not follow pin");

      // Only a pending, enabled source may be reported as winner
      chk_win_enabled: assert property (
         winner.id == ced_id_t'(g + 1) |-> pend_r[g] && SRC_ENABLE[g])
         else $error("winner is not pending and enabled");

      // No candidate may beat the reported maximum
      chk_win_max: assert property (
         pend_r[g] && SRC_ENABLE[g] |-> winner.prio >=
            to_regular(SRC_PRIORITY[g*`CED_PRIO_W +: `CED_PRIO_W], PRIO_REVERSE))
         else $error("candidate above reported maximum");

      // Equal priorities resolve to the lower ID
      chk_win_tie: assert property (
         pend_r[g] && SRC_ENABLE[g] && winner.prio != `CED_PRIO_NONE && winner.prio ==
            to_regular(SRC_PRIORITY[g*`CED_PRIO_W +: `CED_PRIO_W], PRIO_REVERSE)
            |-> winner.id <= ced_id_t'(g + 1))
         else $error("tie not resolved to lower ID");
   end

endmodule // ced_core

// ==== tb/ced_src_model.sv ====
/*
 Partner model of the interrupt source pins feeding the gateways.
 Assumes the bench sets target levels and waits several cycles per change.
*/
module ced_src_model #(
   parameter int N = 4
) (
   input wire logic clk,
   input wire logic [N-1:0] want,
   output logic [N-1:0] req
);
   timeunit 1ns;
   timeprecision 1ns;
   int hold;
   // Start idle, nothing requested
   initial begin
      req = '0;
      hold = 0;
   end
   // Pins move off the sampling edge, then stand three cycles so no pulse is lost
   always @(negedge clk) begin
      if (hold > 0) begin
         hold <= hold - 1;
      end else if (want != req) begin
         req <= want;
         hold <= 2;
      end
   end
endmodule // ced_src_model

// ==== tb/core_ext_interrupt_delivery_tb.sv ====
/*
 Self-checking bench for ced_core with four sources and a reference model.
 Assumes the hand-over latencies: three edges to pending, one to notify.
*/
`define CHK(g, e) check((g), (e))
module core_ext_interrupt_delivery_tb import ced_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int N = 4;
   logic clk, rst, rev, cap, take, mie, meie, exp_n;
   logic [N-1:0] want, req, edg, en, clr, mpend;
   logic [N*4-1:0] prio;
   ced_prio_t th, cl, claim, best;
   ced_id_t bid;
   ced_base_t base;
   logic [N:0] pend;
   logic notify, meip, wake, wake_h, mclr, jv;
   logic [31:0] ptr, jaddr, exp_ptr;
   int fail_count, comparisons;

   ced_src_model #(.N(N)) u_src (.clk(clk), .want(want), .req(req));
   ced_core #(.NUM_SRC(N)) u_dut (.CLK(clk), .RESET(rst), .SRC_REQ(req),
      .GW_EDGE_TYPE(edg), .GW_POLARITY_LOW('0), .SRC_ENABLE(en),
      .SRC_PRIORITY(prio), .GW_CLEAR_WR(clr), .PRIO_REVERSE(rev),
      .PRIO_THRESH(th), .CUR_LEVEL(cl), .VEC_BASE(base), .CAPTURE_WR(cap),
      .MSTATUS_MIE(mie), .MIE_MEIE(meie), .TAKE_EXT_IRQ(take),
      .PENDING_BITS(pend), .EXT_IRQ_NOTIFY(notify), .MIP_MEIP(meip),
      .WAKE_NOTICE(wake), .WAKE_HART(wake_h), .HANDLER_POINTER(ptr),
      .CLAIM_LEVEL(claim), .MIE_CLEAR(mclr), .JUMP_VALID(jv),
      .JUMP_ADDR(jaddr));

   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic check(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Reference tree: ascending IDs with strict compare keeps the lowest on ties
   task automatic verify();
      ced_prio_t p, t, c;
      best = 4'h0;
      bid = 8'h00;
      for (int s = 0; s < N; s++) begin
         p = rev ? ~prio[4*s+:4] : prio[4*s+:4];
         if (mpend[s] && en[s] && p > best) begin
            best = p;
            bid = 8'(s + 1);
         end
      end
      t = rev ? ~th : th;
      c = rev ? ~cl : cl;
      exp_n = best > t && best > c;
      `CHK(pend, {mpend, 1'b0});
      `CHK(notify, exp_n);
      `CHK(meip, exp_n);
      `CHK(wake, best == 4'hF);
      `CHK(wake_h, best == 4'hF && mie && meie);
      `CHK(ptr, exp_ptr);
   endtask

   task automatic capture();
      cap = 1'b1;
      @(negedge clk);
      cap = 1'b0;
      exp_ptr = {base, bid, 2'b00};
      `CHK(ptr, exp_ptr);
      `CHK(claim, ced_prio_t'(rev ? ~best : best));
   endtask

   task automatic take_irq();
      take = 1'b1;
      @(negedge clk);
      take = 1'b0;
      `CHK(jaddr, {base, bid, 2'b00});
      `CHK(mclr, exp_n && mie && meie);
      `CHK(jv, exp_n && mie && meie);
      @(negedge clk);
      `CHK(jv, 1'b0);
   endtask

   // Level bits follow the pin, edge bits latch on a rise only
   task automatic drive(input logic [N-1:0] w);
      mpend = (mpend & edg) | (w & ~want & edg) | (w & ~edg);
      want = w;
      repeat (7) @(negedge clk);
   endtask

   task automatic clear(input logic [N-1:0] m);
      clr = m;
      @(negedge clk);
      clr = '0;
      mpend = mpend & ~(m & edg);
      repeat (3) @(negedge clk);
   endtask

   // Hang guard, far beyond the few hundred cycles the tests take
   initial begin
      #200us;
      fail_count++;
      conclude();
   end

   initial begin
      {rst, rev, cap, take, mie, meie, exp_n} = 7'h40;
      {want, edg, en, clr, mpend, prio, th, cl} = '0;
      exp_ptr = 32'h0;
      fail_count = 0;
      comparisons = 0;
      void'($urandom(87));
      base = 22'($urandom);
      repeat (6) @(negedge clk);
      rst = 1'b0;
      // Random level traffic across both priority orders
      for (int i = 0; i < 24; i++) begin
         en = N'($urandom);
         prio = (N*4)'($urandom);
         {th, cl} = 8'($urandom);
         {rev, mie, meie} = 3'($urandom);
         drive(N'($urandom));
         verify();
         capture();
         take_irq();
      end
      $display("test level done");
      // Edge latching, clear one at a time, then empty claim
      drive('0);
      edg = '1;
      {en, th, cl, rev, mie, meie} = {N'('1), 8'h00, 3'b011};
      prio = 16'h9FF5;
      clear('1);
      drive('1);
      drive('0);
      for (int k = 0; k < N + 1; k++) begin
         verify();
         capture();
         take_irq();
         clear(bid == 8'h00 ? N'(0) : N'(N'(1) << (bid - 8'h01)));
      end
      $display("test edge done");
      conclude();
   end
endmodule // core_ext_interrupt_delivery_tb
